// File: common/aic_params.svh
// Constants of the analog input conditioning block
`ifndef AIC_PARAMS_SVH
`define AIC_PARAMS_SVH
`define AIC_CLK_HZ        50000000
`define AIC_SCAN_MS       20
`define AIC_SCAN_CYC      ((`AIC_CLK_HZ / 1000) * `AIC_SCAN_MS)
`define AIC_SEC_CYC       (`AIC_CLK_HZ)
`define AIC_NSAMP         10
`define AIC_FIFO_DEPTH    32
`define AIC_CH_MAX        6'h20
`define AIC_FILT_MAX      4'hA
`define AIC_DEF_CHANNEL   6'h01
`define AIC_DEF_OFFSET    16'h0000
`define AIC_DEF_SCALE     16'h0064
`define AIC_DEF_FLOOR     16'h8000
`define AIC_DEF_CEIL      16'h7FFF
`define AIC_DEF_THRESH    16'h8000
`define AIC_DEF_DEADBAND  16'h0002
`define AIC_DEF_FILTER    4'h1
`define AIC_DEF_MAXTIME   8'hF0
`define AIC_RAW_FULL      12'hFFF
`define AIC_RAW_ZERO      12'h000
`define AIC_SPAN_10V      16'h2710
`define AIC_SPAN_5V       16'h1388
`define AIC_CRC_INIT      16'hFFFF
`define AIC_CRC_POLY      16'hA001
`define AIC_ST_OK         8'h00
`define AIC_ST_OVER       8'h01
`define AIC_ST_UNDER      8'h02
`define AIC_ST_CFGCHG     8'h03
`define AIC_ST_CRCERR     8'h04
`define AIC_TEXT_DEPTH    45
`define AIC_TEXT_LAST     6'h2C
`define AIC_ASCII_LO      8'h20
`define AIC_ASCII_HI      8'h7E
`endif

// File: common/aic_pkg.sv
// Types of the analog input conditioning block
package aic_pkg;
    typedef enum logic [1:0] {
        AIC_MODE_REAL = 2'h0,
        AIC_MODE_INT  = 2'h1,
        AIC_MODE_V10  = 2'h2,
        AIC_MODE_V5   = 2'h3
    } aic_mode_t;
    typedef enum logic [1:0] {
        AIC_PRIO_NO   = 2'h0,
        AIC_PRIO_LOW  = 2'h1,
        AIC_PRIO_HIGH = 2'h2
    } aic_prio_t;
    typedef enum logic [3:0] {
        AIC_S_IDLE = 4'h1,
        AIC_S_WAIT = 4'h2,
        AIC_S_CALC = 4'h4,
        AIC_S_POST = 4'h8
    } aic_state_t;
endpackage

// File: verilog/aic_fifo.sv
// Report FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module aic_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } aic_fifo_st_t;
    aic_fifo_st_t q;
    aic_fifo_st_t n;
    logic         push;
    logic         pop;

    assign in_ready_o  = (q.cnt != (AW + 1)'(DEPTH));
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o  = q.mem[q.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wp] = in_data_i;
            n.wp        = (q.wp == (AW)'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (q.rp == (AW)'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        n.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule
`default_nettype wire

// File: verilog/aic_top.sv
// Analog input point: scan, filter, scale, clamp, change detection and reporting
`timescale 1ns/1ps
`default_nettype none
`include "aic_params.svh"
module aic_top
    import aic_pkg::*;
#(
    parameter int SCAN_CYC = `AIC_SCAN_CYC,
    parameter int SEC_CYC  = `AIC_SEC_CYC
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RSTN_I,
    input  wire logic        CFG_LOAD_I,
    input  wire logic [5:0]  CFG_CHANNEL_I,
    input  wire logic [1:0]  CFG_MODE_I,
    input  wire logic [15:0] CFG_OFFSET_I,
    input  wire logic [15:0] CFG_SCALE_I,
    input  wire logic [15:0] CFG_FLOOR_I,
    input  wire logic [15:0] CFG_CEIL_I,
    input  wire logic [15:0] CFG_THRESH_I,
    input  wire logic [15:0] CFG_DEADBAND_I,
    input  wire logic [3:0]  CFG_FILTER_I,
    input  wire logic [1:0]  CFG_PRIO_I,
    input  wire logic [7:0]  CFG_MAXTIME_I,
    input  wire logic [15:0] SYS_BIAS_I,
    input  wire logic [15:0] SYS_SCALE_I,
    input  wire logic        CRC_CHECK_I,
    input  wire logic [15:0] CRC_REF_I,
    input  wire logic        TEXT_WE_I,
    input  wire logic [5:0]  TEXT_ADDR_I,
    input  wire logic [7:0]  TEXT_DATA_I,
    output logic [7:0]       TEXT_RDATA_O,
    output logic             ADC_START_O,
    output logic [5:0]       ADC_CHAN_O,
    input  wire logic        ADC_DONE_I,
    input  wire logic [11:0] ADC_DATA_I,
    output logic             REPORT_VALID_O,
    input  wire logic        REPORT_READY_I,
    output logic [31:0]      REPORT_VALUE_O,
    output logic [1:0]       REPORT_PRIO_O,
    output logic [31:0]      VALUE_O,
    output logic [11:0]      SAMPLE_O,
    output logic [7:0]       COND_CODE_O,
    output logic [15:0]      CONFIG_CRC_O,
    output logic             COS_O,
    output logic [31:0]      LAST_CHANGE_O,
    output logic [31:0]      TIME_SEC_O
);
    localparam int NS = `AIC_NSAMP;
    typedef struct packed {
        aic_state_t                   st;
        logic [31:0]                  scan_cnt;
        logic [31:0]                  sec_cnt;
        logic [31:0]                  time_sec;
        logic [5:0]                   channel;
        aic_mode_t                    mode;
        logic [15:0]                  offset;
        logic [15:0]                  scale;
        logic [15:0]                  floor_v;
        logic [15:0]                  ceil_v;
        logic [15:0]                  thresh;
        logic [15:0]                  deadband;
        logic [3:0]                   filter;
        aic_prio_t                    prio;
        logic [7:0]                   maxtime;
        logic [NS-1:0][11:0]          samples;
        logic [3:0]                   nfill;
        logic [11:0]                  raw;
        logic [11:0]                  mean;
        logic [31:0]                  value;
        logic [31:0]                  last_rep;
        logic [7:0]                   rep_age;
        logic                         pend;
        logic [33:0]                  pend_data;
        logic                         cos;
        logic [31:0]                  last_change;
        logic [15:0]                  crc;
        logic                         cfg_chg;
        logic [7:0]                   cond;
        logic [`AIC_TEXT_DEPTH-1:0][7:0] text;
        logic [7:0]                   text_rd;
        logic                         adc_start;
        logic                         out_v;
        logic [33:0]                  out_data;
    } aic_st_t;
    aic_st_t             q;
    aic_st_t             n;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    logic [33:0]         fifo_out_data;
    logic [3:0]          navg;
    logic [15:0]         sum_w;
    logic [36:0]         quot_w;
    logic [15:0]         base_w;
    logic [15:0]         span_w;
    logic signed [28:0]  prod_w;
    logic signed [31:0]  p32_w;
    logic signed [31:0]  scaled_w;
    logic signed [31:0]  v1_w;
    logic signed [31:0]  v2_w;
    logic signed [31:0]  v3_w;
    logic signed [32:0]  diff_w;
    logic [32:0]         adiff_w;
    logic                due_w;
    logic [15:0]         crc_w;

    // Reciprocal of 2**20 rounded up; exact floor divide for sums below 2**16
    function automatic logic [20:0] f_recip(input logic [3:0] k);
        case (k)
            4'h2:    return 21'h08_0000;
            4'h3:    return 21'h05_5556;
            4'h4:    return 21'h04_0000;
            4'h5:    return 21'h03_3334;
            4'h6:    return 21'h02_AAAB;
            4'h7:    return 21'h02_4925;
            4'h8:    return 21'h02_0000;
            4'h9:    return 21'h01_C71D;
            4'hA:    return 21'h01_999A;
            default: return 21'h10_0000;
        endcase
    endfunction

    function automatic logic [15:0] f_sum(input logic [NS-1:0][11:0] s, input logic [3:0] k);
        logic [15:0] acc;
        acc = 16'h0000;
        for (int i = 0; i < NS; i++) begin
            if (4'(i) < k) begin
                acc = acc + 16'(s[i]);
            end
        end
        return acc;
    endfunction

    function automatic logic [15:0] f_crc(input logic [117:0] d);
        logic [15:0] c;
        c = `AIC_CRC_INIT;
        for (int i = 0; i < 118; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ `AIC_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // Fewer stored readings than the filter asks for are averaged as they stand
    assign navg     = (q.nfill < q.filter) ? q.nfill : q.filter;
    assign sum_w    = f_sum(q.samples, navg);
    assign quot_w   = 37'(sum_w) * 37'(f_recip(navg));
    assign prod_w   = $signed({1'b0, q.mean}) * $signed(span_w);
    assign p32_w    = 32'(prod_w);
    // Divide by full scale 4095 so that an all-ones sample yields the full span for spans up to 4096
    assign scaled_w = 32'($signed(base_w)) + ((p32_w + (p32_w >>> 12) + 32'sd1) >>> 12);
    assign v1_w     = (scaled_w < 32'($signed(q.floor_v))) ? 32'($signed(q.floor_v)) : scaled_w;
    assign v2_w     = (v1_w > 32'($signed(q.ceil_v))) ? 32'($signed(q.ceil_v)) : v1_w;
    assign v3_w     = (v2_w < 32'($signed(q.thresh))) ? 32'($signed(q.floor_v)) : v2_w;
    assign diff_w   = 33'(v3_w) - 33'($signed(q.last_rep));
    assign adiff_w  = diff_w[32] ? 33'(-diff_w) : 33'(diff_w);
    assign due_w    = (q.maxtime != 8'h00) && (q.rep_age >= q.maxtime);
    assign crc_w    = f_crc({q.channel, q.mode, q.offset, q.scale, q.floor_v, q.ceil_v, q.thresh,
                             q.deadband, q.filter, q.prio, q.maxtime});
    assign fifo_out_ready = !q.out_v || REPORT_READY_I;

    always_comb begin
        unique case (q.mode)
            AIC_MODE_REAL: begin
                base_w = q.offset;
                span_w = q.scale;
            end
            AIC_MODE_INT: begin
                base_w = SYS_BIAS_I;
                span_w = SYS_SCALE_I;
            end
            AIC_MODE_V10: begin
                base_w = 16'h0000;
                span_w = `AIC_SPAN_10V;
            end
            AIC_MODE_V5: begin
                base_w = 16'h0000;
                span_w = `AIC_SPAN_5V;
            end
        endcase
    end

    always_comb begin
        n           = q;
        n.adc_start = 1'b0;
        n.cos       = 1'b0;
        n.crc       = crc_w;
        // Free-running seconds time base and report age
        if (q.sec_cnt == 32'(SEC_CYC - 1)) begin
            n.sec_cnt  = 32'h0000_0000;
            n.time_sec = q.time_sec + 32'h0000_0001;
            if (q.rep_age != 8'hFF) begin
                n.rep_age = q.rep_age + 8'h01;
            end
        end else begin
            n.sec_cnt = q.sec_cnt + 32'h0000_0001;
        end
        // Out-of-range settings are refused and the old value kept
        if (CFG_LOAD_I) begin
            if (CFG_CHANNEL_I <= `AIC_CH_MAX) begin
                n.channel = CFG_CHANNEL_I;
            end
            if (CFG_FILTER_I != 4'h0 && CFG_FILTER_I <= `AIC_FILT_MAX) begin
                n.filter = CFG_FILTER_I;
            end
            if (CFG_PRIO_I != 2'h3) begin
                n.prio = aic_prio_t'(CFG_PRIO_I);
            end
            n.mode     = aic_mode_t'(CFG_MODE_I);
            n.offset   = CFG_OFFSET_I;
            n.scale    = CFG_SCALE_I;
            n.floor_v  = CFG_FLOOR_I;
            n.ceil_v   = CFG_CEIL_I;
            n.thresh   = CFG_THRESH_I;
            n.deadband = CFG_DEADBAND_I;
            n.maxtime  = CFG_MAXTIME_I;
        end
        // Text store: only printable bytes within the 45-byte area are kept
        if (TEXT_WE_I && TEXT_ADDR_I <= `AIC_TEXT_LAST
            && TEXT_DATA_I >= `AIC_ASCII_LO && TEXT_DATA_I <= `AIC_ASCII_HI) begin
            n.text[TEXT_ADDR_I] = TEXT_DATA_I;
        end
        n.text_rd = (TEXT_ADDR_I <= `AIC_TEXT_LAST) ? q.text[TEXT_ADDR_I] : 8'h00;
        // Scan timer keeps real time; a tick during a busy conversion is dropped
        if (q.scan_cnt == 32'(SCAN_CYC - 1)) begin
            n.scan_cnt = 32'h0000_0000;
            if (q.st == AIC_S_IDLE && q.channel != 6'h00) begin
                n.adc_start = 1'b1;
                n.st        = AIC_S_WAIT;
            end
        end else begin
            n.scan_cnt = q.scan_cnt + 32'h0000_0001;
        end
        unique case (q.st)
            AIC_S_IDLE: begin
            end
            AIC_S_WAIT: begin
                if (ADC_DONE_I) begin
                    n.raw     = ADC_DATA_I;
                    n.samples = {q.samples[NS-2:0], ADC_DATA_I};
                    n.nfill   = (q.nfill == 4'(NS)) ? q.nfill : q.nfill + 4'h1;
                    n.st      = AIC_S_CALC;
                end
            end
            AIC_S_CALC: begin
                n.mean = quot_w[31:20];
                n.st   = AIC_S_POST;
            end
            AIC_S_POST: begin
                n.value = v3_w;
                n.st    = AIC_S_IDLE;
                if (adiff_w >= 33'(q.deadband)) begin
                    n.cos         = 1'b1;
                    n.last_rep    = v3_w;
                    n.last_change = n.time_sec;
                end
                if ((n.cos || due_w) && q.prio != AIC_PRIO_NO) begin
                    n.pend_data = {q.prio, v3_w};
                    n.rep_age   = 8'h00;
                end
                if (q.raw == `AIC_RAW_FULL) begin
                    n.cond = `AIC_ST_OVER;
                end else if (q.raw == `AIC_RAW_ZERO) begin
                    n.cond = `AIC_ST_UNDER;
                end else begin
                    n.cond = `AIC_ST_OK;
                end
                n.cfg_chg = 1'b0;
            end
        endcase
        // A new report replaces a waiting one; set wins over the handshake clear
        if (q.pend && fifo_in_ready) begin
            n.pend = 1'b0;
        end
        if (q.st == AIC_S_POST && (n.cos || due_w) && q.prio != AIC_PRIO_NO) begin
            n.pend = 1'b1;
        end
        if (q.crc != crc_w) begin
            n.cfg_chg = 1'b1;
        end
        // Checksum error outranks config change, which outranks the range codes
        if (CRC_CHECK_I && crc_w != CRC_REF_I) begin
            n.cond = `AIC_ST_CRCERR;
        end else if (n.cfg_chg) begin
            n.cond = `AIC_ST_CFGCHG;
        end else if (q.st != AIC_S_POST && (q.cond == `AIC_ST_CRCERR || q.cond == `AIC_ST_CFGCHG)) begin
            n.cond = `AIC_ST_OK;
        end
        if (fifo_out_ready) begin
            n.out_v    = fifo_out_valid;
            n.out_data = fifo_out_data;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            q          <= '0;
            q.st       <= AIC_S_IDLE;
            q.channel  <= `AIC_DEF_CHANNEL;
            q.mode     <= AIC_MODE_REAL;
            q.offset   <= `AIC_DEF_OFFSET;
            q.scale    <= `AIC_DEF_SCALE;
            q.floor_v  <= `AIC_DEF_FLOOR;
            q.ceil_v   <= `AIC_DEF_CEIL;
            q.thresh   <= `AIC_DEF_THRESH;
            q.deadband <= `AIC_DEF_DEADBAND;
            q.filter   <= `AIC_DEF_FILTER;
            q.prio     <= AIC_PRIO_HIGH;
            q.maxtime  <= `AIC_DEF_MAXTIME;
            q.crc      <= `AIC_CRC_INIT;
        end else begin
            q <= n;
        end
    end

    aic_fifo #(
        .WIDTH (34),
        .DEPTH (`AIC_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_SYS_I),
        .rst_n_i     (RSTN_I),
        .in_valid_i  (q.pend),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (q.pend_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    assign TEXT_RDATA_O   = q.text_rd;
    assign ADC_START_O    = q.adc_start;
    assign ADC_CHAN_O     = q.channel;
    assign REPORT_VALID_O = q.out_v;
    assign REPORT_PRIO_O  = q.out_data[33:32];
    assign REPORT_VALUE_O = q.out_data[31:0];
    assign VALUE_O        = q.value;
    assign SAMPLE_O       = q.raw;
    assign COND_CODE_O    = q.cond;
    assign CONFIG_CRC_O   = q.crc;
    assign COS_O          = q.cos;
    assign LAST_CHANGE_O  = q.last_change;
    assign TIME_SEC_O     = q.time_sec;

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    chk_chan_gate: assert property (ADC_START_O |-> $past(q.channel) != 6'h00)
        else $error("conversion started on a disabled channel");
    chk_clamp_low: assert property ($past(q.st) == AIC_S_POST && $stable(q.floor_v) && $stable(q.ceil_v)
        && $signed(q.floor_v) <= $signed(q.ceil_v) |-> $signed(VALUE_O) >= 32'($signed(q.floor_v)))
        else $error("value below floor");
    chk_clamp_high: assert property ($past(q.st) == AIC_S_POST && $stable(q.floor_v) && $stable(q.ceil_v)
        && $signed(q.floor_v) <= $signed(q.ceil_v) |-> $signed(VALUE_O) <= 32'($signed(q.ceil_v)))
        else $error("value above ceiling");
    chk_thresh_floor: assert property (q.st == AIC_S_POST ##1 $stable(q.thresh) && $stable(q.floor_v)
        |-> $signed(VALUE_O) >= 32'($signed(q.thresh)) || VALUE_O == 32'($signed(q.floor_v)))
        else $error("value under threshold not forced to floor");
    chk_filter_range: assert property (q.filter != 4'h0 && q.filter <= `AIC_FILT_MAX)
        else $error("filter count out of range");
    chk_report_prio: assert property ($rose(q.pend) |-> q.pend_data[33:32] != AIC_PRIO_NO)
        else $error("report queued with priority No");
    chk_raw_over: assert property (q.st == AIC_S_POST && q.raw == `AIC_RAW_FULL && !CRC_CHECK_I && !q.cfg_chg
        && q.crc == crc_w |=> COND_CODE_O == `AIC_ST_OVER)
        else $error("overrange code missing");
    chk_scan_gap: assert property (ADC_START_O |=> !ADC_START_O [*8])
        else $error("scan starts too close together");
    chk_cos_stamp: assert property (COS_O |-> LAST_CHANGE_O == TIME_SEC_O)
        else $error("change time not stamped");
    chk_conv_wait: assert property (ADC_START_O |-> q.st == AIC_S_WAIT)
        else $error("start without waiting for converter");

    cov_change: cover property (COS_O);
    cov_report: cover property (REPORT_VALID_O && REPORT_READY_I);
    cov_crc_err: cover property (COND_CODE_O == `AIC_ST_CRCERR);
    cov_forced: cover property (q.st == AIC_S_POST && due_w && !n.cos);
endmodule
`default_nettype wire

// File: testbench/aic_adc_model.sv
// Converter and host reporting partner model
`timescale 1ns/1ps
`default_nettype none
module aic_adc_model (
    input  wire logic   clk_i,
    input  wire logic   start_i,
    output logic        done_o,
    output logic [11:0] data_o,
    input  wire logic   rep_valid_i,
    output logic        rep_ready_o
);
    logic [11:0] da = 12'h000;
    logic [11:0] db = 12'h000;
    logic        alt = 1'b0;
    int          slow = 0;
    int          stall = 0;
    initial begin
        done_o = 1'b0;
        data_o = 12'h000;
        rep_ready_o = 1'b1;
    end
    // Alternating words let the bench tell a mean from a single reading
    always @(posedge clk_i) begin
        if (start_i) begin
            repeat (1 + slow) @(posedge clk_i);
            done_o <= 1'b1;
            data_o <= alt ? db : da;
            alt <= !alt;
            @(posedge clk_i);
            done_o <= 1'b0;
            // Released bus shows the inverse so a stale word never looks valid
            data_o <= ~data_o;
        end
    end
    always @(posedge clk_i) rep_ready_o <= (stall != 0 && rep_valid_i) ? ~rep_ready_o : 1'b1;
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the analog input point
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import aic_pkg::*;
    localparam int SC = 200;
    logic               clk = 1'b0, rstn = 1'b0, load = 1'b0, crc_chk = 1'b0, twe = 1'b0;
    logic [5:0]         ch = 6'h01, taddr = 6'h00;
    logic [1:0]         mode = 2'h0, prio = 2'h2, rprio, prio_last;
    logic signed [15:0] off = 16'h0000, scl = 16'h0064, flo = 16'h8000, cei = 16'h7FFF, thr = 16'h8000;
    logic signed [15:0] sb = 16'h0000, ss = 16'h0064;
    logic [15:0]        db = 16'h0002, crc, cref = 16'h0000;
    logic [3:0]         fil = 4'h1;
    logic [7:0]         mt = 8'hF0, tdat = 8'h00, cond, trd;
    logic               start, done, rv, rr, cos;
    logic [11:0]        adat, samp;
    logic [5:0]         achan;
    logic [31:0]        rval, val, lastc, tsec, rep_last;
    int                 bad_count = 0, n_compared = 0, seed = 32'h2470_71b1, n_start = 0, n_cos = 0, n_rep = 0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (start) n_start++;
        if (cos) begin
            n_cos++;
            chk(lastc, tsec);
        end
        if (rv && rr) begin
            n_rep++;
            rep_last = rval;
            prio_last = rprio;
        end
    end
    aic_top #(.SCAN_CYC(SC), .SEC_CYC(1000)) dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .CFG_LOAD_I(load),
        .CFG_CHANNEL_I(ch), .CFG_MODE_I(mode), .CFG_OFFSET_I(off), .CFG_SCALE_I(scl), .CFG_FLOOR_I(flo),
        .CFG_CEIL_I(cei), .CFG_THRESH_I(thr), .CFG_DEADBAND_I(db), .CFG_FILTER_I(fil), .CFG_PRIO_I(prio),
        .CFG_MAXTIME_I(mt), .SYS_BIAS_I(sb), .SYS_SCALE_I(ss), .CRC_CHECK_I(crc_chk), .CRC_REF_I(cref),
        .TEXT_WE_I(twe), .TEXT_ADDR_I(taddr), .TEXT_DATA_I(tdat), .TEXT_RDATA_O(trd), .ADC_START_O(start),
        .ADC_CHAN_O(achan), .ADC_DONE_I(done), .ADC_DATA_I(adat), .REPORT_VALID_O(rv), .REPORT_READY_I(rr),
        .REPORT_VALUE_O(rval), .REPORT_PRIO_O(rprio), .VALUE_O(val), .SAMPLE_O(samp), .COND_CODE_O(cond),
        .CONFIG_CRC_O(crc), .COS_O(cos), .LAST_CHANGE_O(lastc), .TIME_SEC_O(tsec));
    aic_adc_model m (.clk_i(clk), .start_i(start), .done_o(done), .data_o(adat), .rep_valid_i(rv), .rep_ready_o(rr));
    function automatic logic signed [31:0] calc(input logic [11:0] s);
        logic signed [31:0] base, span, p, v;
        base = mode == 2'h0 ? 32'(off) : mode == 2'h1 ? 32'(sb) : 32'sh0;
        span = mode == 2'h0 ? 32'(scl) : mode == 2'h1 ? 32'(ss) : mode == 2'h2 ? 32'sh0000_2710 : 32'sh0000_1388;
        p = $signed({20'h0, s}) * span;
        v = base + ((p + (p >>> 12) + 32'sh1) >>> 12);
        if (v < flo) v = flo;
        if (v > cei) v = cei;
        if (v < thr) v = flo;
        return v;
    endfunction
    // Reflected CRC-16, low bit of the configuration first
    function automatic logic [15:0] crc16(input logic [117:0] d);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < 118; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        return c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cfg();
        @(negedge clk) load = 1'b1;
        @(negedge clk) load = 1'b0;
    endtask
    task automatic run(input logic [11:0] a, input logic [11:0] b, input int n);
        m.da = a;
        m.db = b;
        repeat (n * SC + 20) @(negedge clk);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Whole sequence needs about 26500 cycles
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        logic [11:0] a, b;
        int n, d;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        chk(achan, 32'h0000_0001);
        chk(crc, 32'h0000_FFFF);
        run(12'hFFF, 12'hFFF, 2);
        chk(val, calc(12'hFFF));
        chk(cond, 32'h0000_0001);
        $display("test defaults done");
        for (int k = 0; k < 12; k++) begin
            mode = k[1:0];
            off = 16'($random(seed));
            scl = 16'($random(seed));
            sb = 16'($random(seed));
            ss = 16'($random(seed));
            m.slow = $random(seed) & 31;
            a = k == 4 ? 12'h000 : 12'($random(seed));
            cfg();
            run(a, a, 3);
            chk(val, calc(a));
            chk(samp, a);
            chk(cond, a == 12'hFFF ? 32'h1 : a == 12'h000 ? 32'h2 : 32'h0);
        end
        $display("test modes done");
        mode = 2'h2;
        fil = 4'h2;
        cfg();
        run(12'h100, 12'h301, 3);
        chk(val, calc(12'h200));
        fil = 4'hB;
        cfg();
        run(12'h100, 12'h301, 3);
        chk(val, calc(12'h200));
        fil = 4'h1;
        for (int k = 0; k < 3; k++) begin
            flo = k == 0 ? 16'h1800 : 16'h0064;
            cei = k == 1 ? 16'h0BB8 : 16'h7FFF;
            thr = k == 2 ? 16'h1770 : 16'h8000;
            cfg();
            run(12'h800, 12'h800, 2);
            chk(val, calc(12'h800));
        end
        flo = 16'h8000;
        thr = 16'h8000;
        db = 16'h0005;
        cfg();
        for (int k = 0; k < 6; k++) begin
            a = 12'h400 + 12'($random(seed) & 255);
            b = a + 12'(k);
            run(12'h000, 12'h000, 2);
            run(a, a, 2);
            n = n_cos;
            run(b, b, 2);
            d = calc(b) - calc(a);
            chk(32'(n_cos != n), 32'(d >= 5 || d <= -5));
        end
        $display("test filter clamp deadband done");
        m.stall = 1;
        prio = 2'h1;
        cfg();
        run(12'hA00, 12'hA00, 2);
        chk(rep_last, calc(12'hA00));
        chk(prio_last, 32'h1);
        prio = 2'h0;
        cfg();
        n = n_rep;
        run(12'h000, 12'h000, 2);
        chk(n_rep, n);
        prio = 2'h2;
        mt = 8'h01;
        cfg();
        n = n_rep;
        run(12'h000, 12'h000, 15);
        chk(32'(n_rep - n >= 2), 32'h1);
        chk(prio_last, 32'h2);
        mt = 8'h00;
        cfg();
        run(12'h000, 12'h000, 2);
        n = n_rep;
        run(12'h000, 12'h000, 15);
        chk(n_rep, n);
        $display("test reports done");
        ch = 6'h00;
        cfg();
        // A conversion still in flight may end the change code one edge later
        repeat (1) @(negedge clk);
        chk(cond, 32'h3);
        n = n_start;
        run(12'h000, 12'h000, 3);
        chk(n_start, n);
        ch = 6'h20;
        cfg();
        run(12'h000, 12'h000, 2);
        chk(32'(n_start > n), 32'h1);
        cref = crc16({ch, mode, off, scl, flo, cei, thr, db, fil, prio, mt});
        chk(crc, cref);
        ch = 6'h21;
        cfg();
        run(12'h000, 12'h000, 1);
        chk(achan, 32'h20);
        crc_chk = 1'b1;
        repeat (3) @(negedge clk);
        chk(32'(cond == 8'h04), 32'h0);
        cref = ~cref;
        repeat (3) @(negedge clk);
        chk(cond, 32'h4);
        crc_chk = 1'b0;
        taddr = 6'h2C;
        tdat = 8'h41;
        twe = 1'b1;
        @(negedge clk) twe = 1'b0;
        repeat (2) @(negedge clk);
        chk(trd, 32'h41);
        taddr = 6'h0E;
        tdat = 8'h07;
        twe = 1'b1;
        @(negedge clk) twe = 1'b0;
        repeat (2) @(negedge clk);
        chk(trd, 32'h0);
        $display("test channel code text done");
        finish_test();
    end
endmodule
`default_nettype wire
